// ==== inc/rps_map.vh ====
// Register map, field positions and timing counts of the ring port switch.
`ifndef RPS_MAP_VH
`define RPS_MAP_VH

// ==========================================================================
// Register byte offsets
`define RPS_CTRL_ADDR        4'h0
`define RPS_STATUS_ADDR      4'h4

// ==========================================================================
// Control register fields and reset value
`define RPS_CTRL_FWD_BIT     0
`define RPS_CTRL_RESET       32'h0000_0001

// ==========================================================================
// Status register fields
`define RPS_ST_MODE_LSB      0
`define RPS_ST_MODE_MSB      2
`define RPS_ST_LOCAL_BIT     4
`define RPS_ST_OFF_BIT       5
`define RPS_ST_DIL_LSB       8
`define RPS_ST_DIL_MSB       11
`define RPS_ST_REM_LSB       12
`define RPS_ST_REM_MSB       15

// ==========================================================================
// Mode codes: 0 is no switching mode, 1..4 follow the four selects
`define RPS_MODE_OFF         3'h0
`define RPS_MODE_W           3

// ==========================================================================
// AXI response codes
`define RPS_RESP_OKAY        2'h0
`define RPS_RESP_SLVERR      2'h2

// ==========================================================================
// Input smoothing time and clock rate
`define RPS_SMOOTH_US        5000
`define RPS_CLK_MHZ          20
`define RPS_SMOOTH_CYC       (`RPS_SMOOTH_US * `RPS_CLK_MHZ)

`endif

// ==== core/rps_switch.v ====
// Control and routing logic of the four-port ring switch.
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns
// Function
// R1: Four ports, each with one receive input and one transmit output.
// R2: Any receive input drives at most one transmit output at a time.
// R3: Routing pattern is chosen from local DIL switches or remote inputs.
// R4: When both sources request a mode, local switches win.
// R5: Five front-panel indicator outputs show the selected switch position; here three, led_position, carry it as a binary code.
// R6: One indicator lights for local selection, one for no mode selected.
// R7: Passive element: no address, only forwards along the selected paths.
// R8: Remote side requests a mode by asserting one of four inputs.
// R9: Selection inputs are synchronised and debounced before routes change.
`include "rps_map.vh"

module rps_switch #(
    parameter PORTS      = 4,
    parameter SMOOTH_CYC = `RPS_SMOOTH_CYC
)(
    // Clock and reset
    input  wire         aclk,
    input  wire         aresetn,
    // AXI4-Lite write address and data
    input  wire [3:0]   s_axi_awaddr,
    input  wire         s_axi_awvalid,
    output reg          s_axi_awready,
    input  wire [31:0]  s_axi_wdata,
    input  wire [3:0]   s_axi_wstrb,
    input  wire         s_axi_wvalid,
    output reg          s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]   s_axi_bresp,
    output reg          s_axi_bvalid,
    input  wire         s_axi_bready,
    // AXI4-Lite read
    input  wire [3:0]   s_axi_araddr,
    input  wire         s_axi_arvalid,
    output reg          s_axi_arready,
    output reg  [31:0]  s_axi_rdata,
    output reg  [1:0]   s_axi_rresp,
    output reg          s_axi_rvalid,
    input  wire         s_axi_rready,
    // Mode selection: local DIL switches and remote binary inputs
    input  wire [3:0]   dil_mode_select,
    input  wire         port_one_mode_select,
    input  wire         port_two_mode_select,
    input  wire         port_three_mode_select,
    input  wire         port_four_mode_select,
    // Ring ports, electrical side of the optical modules
    input  wire [PORTS-1:0] ring_rx,
    output reg  [PORTS-1:0] ring_tx,
    // Front panel indicators
    output reg  [2:0]   led_position,
    output reg          led_local,
    output reg          led_off
);

    // ======================================================================
    // Helpers

    // Lowest-numbered active select wins; zero means no mode requested.
    function [`RPS_MODE_W-1:0] pick_mode;
        input [3:0] sel;
        begin
            if (sel[0])
                pick_mode = 3'h1;
            else if (sel[1])
                pick_mode = 3'h2;
            else if (sel[2])
                pick_mode = 3'h3;
            else if (sel[3])
                pick_mode = 3'h4;
            else
                pick_mode = `RPS_MODE_OFF;
        end
    endfunction

    // Source port feeding transmit port dst in a given mode. Every mode is
    // a permutation, so no receive input can fan out to two outputs.
    function [1:0] route_src;
        input [`RPS_MODE_W-1:0] mode;
        input [1:0]             dst;
        begin
            case (mode)
                3'h1:    route_src = {dst[1], ~dst[0]};   // see R2
                3'h2:    route_src = {~dst[1], dst[0]};   // see R2
                3'h3:    route_src = ~dst;                // see R2
                3'h4:    route_src = dst + 2'h1;          // see R2
                default: route_src = dst;                 // see R2
            endcase
        end
    endfunction

    // ======================================================================
    // Selection input conditioning

    wire [7:0] sel_raw = {port_four_mode_select, port_three_mode_select,
                          port_two_mode_select, port_one_mode_select,
                          dil_mode_select};

    reg  [7:0]  sync1_q;
    reg  [7:0]  sync2_q;
    reg  [7:0]  stable_q;
    reg  [7:0]  prev_q;
    reg  [31:0] dbnc_cnt_q;

    // Two flops then a hold timer; a glitch shorter than the hold time
    // never reaches the routing, at the cost of a slow mode change.
    // The timer restarts whenever the synchronised pattern moves, so a
    // value is only adopted once it has stood for the whole hold time.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_q    <= 8'h00;
            sync2_q    <= 8'h00;
            stable_q   <= 8'h00;
            prev_q     <= 8'h00;
            dbnc_cnt_q <= 32'h0000_0000;
        end
        else
        begin
            sync1_q <= sel_raw;                                 // see R9
            sync2_q <= sync1_q;                                 // see R9
            prev_q  <= sync2_q;                                 // see R9
            if (sync2_q == stable_q || sync2_q != prev_q)
                dbnc_cnt_q <= 32'h0000_0000;
            else if (dbnc_cnt_q >= SMOOTH_CYC - 1)
            begin
                stable_q   <= sync2_q;                          // see R9
                dbnc_cnt_q <= 32'h0000_0000;
            end
            else
                dbnc_cnt_q <= dbnc_cnt_q + 32'h0000_0001;
        end
    end

    // ======================================================================
    // Mode decision

    wire [3:0] dil_q      = stable_q[3:0];
    wire [3:0] rem_q      = stable_q[7:4];                      // see R8
    wire       local_sel  = |dil_q;
    // Local switches override whatever the remote inputs ask for.
    wire [`RPS_MODE_W-1:0] mode_sel =
        local_sel ? pick_mode(dil_q) : pick_mode(rem_q);        // see R3 R4

    reg  [`RPS_MODE_W-1:0] mode_q;
    reg  [31:0]            ctrl_q;

    // ======================================================================
    // Routing matrix and indicators

    integer d;
    reg [PORTS-1:0] tx_d;
    // Pure forwarding: each output copies exactly one receive input, or all drive low while the forward bit is clear.
    always @*
    begin
        tx_d = {PORTS{1'b0}};
        for (d = 0; d < PORTS; d = d + 1)
            tx_d[d] = ring_rx[route_src(mode_q, d[1:0])];      // see R1 R7
        if (!ctrl_q[`RPS_CTRL_FWD_BIT])
            tx_d = {PORTS{1'b0}};
    end

    // Mode and panel state are registered so all outputs come from flops.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode_q       <= `RPS_MODE_OFF;
            ring_tx      <= {PORTS{1'b0}};
            led_position <= 3'h0;
            led_local    <= 1'b0;
            led_off      <= 1'b1;
        end
        else
        begin
            mode_q       <= mode_sel;                           // see R3
            ring_tx      <= tx_d;                               // see R7
            led_position <= mode_q;                             // see R5
            led_local    <= local_sel;                          // see R6
            led_off      <= (mode_sel == `RPS_MODE_OFF);        // see R6
        end
    end

    // ======================================================================
    // AXI4-Lite slave

    wire [31:0] status_w = {16'h0000, rem_q, dil_q, 2'b00,
                            led_off, led_local, 1'b0, mode_q};

    reg  [3:0]  awaddr_q;
    reg  [31:0] wdata_q;
    reg  [3:0]  wstrb_q;
    integer     b;

    // Address and data are taken independently; once both are held, the
    // write and the response happen together on the following cycle.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RPS_RESP_OKAY;
            awaddr_q      <= 4'h0;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
            ctrl_q        <= `RPS_CTRL_RESET;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awaddr_q      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wdata_q      <= s_axi_wdata;
                wstrb_q      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid)
            begin
                s_axi_bvalid <= 1'b1;
                if ({awaddr_q[3:2], 2'b00} == `RPS_CTRL_ADDR)
                begin
                    s_axi_bresp <= `RPS_RESP_OKAY;
                    for (b = 0; b < 4; b = b + 1)
                        if (wstrb_q[b])
                            ctrl_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
                end
                else if ({awaddr_q[3:2], 2'b00} == `RPS_STATUS_ADDR)
                    s_axi_bresp <= `RPS_RESP_OKAY;      // Read-only, ignored.
                else
                    s_axi_bresp <= `RPS_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Reads answer one cycle after the address is taken.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RPS_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `RPS_RESP_OKAY;
            case ({s_axi_araddr[3:2], 2'b00})
                `RPS_CTRL_ADDR:   s_axi_rdata <= ctrl_q & 32'h0000_0001;
                `RPS_STATUS_ADDR: s_axi_rdata <= status_w;
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `RPS_RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule

// ==== test/rps_monitor.sv ====
// Port checker of the ring switch, bound to its top module.
`timescale 1ns/1ns
module rps_monitor (
    input wire        aclk, aresetn,
    input wire        s_axi_awvalid, s_axi_awready, s_axi_wvalid,
    input wire        s_axi_wready, s_axi_bvalid, s_axi_bready,
    input wire        s_axi_arvalid, s_axi_arready, s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [1:0]  s_axi_bresp,
    input wire [31:0] s_axi_rdata,
    input wire [3:0]  dil_mode_select, ring_rx, ring_tx,
    input wire        port_one_mode_select, port_two_mode_select,
    input wire        port_three_mode_select, port_four_mode_select,
    input wire [2:0]  led_position,
    input wire        led_local, led_off
);
    // All selection inputs in one vector, local switches on top.
    wire [7:0] sel_all = {dil_mode_select, port_four_mode_select,
        port_three_mode_select, port_two_mode_select, port_one_mode_select};
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ======================================================================
    // Indicators and routing.
    property p_pos_range; led_position <= 3'h4; endproperty
    a_pos_range: assert property (p_pos_range)
        else $error("position out of range");
    property p_off_pos; 1 |=> (led_position == 3'h0) == $past(led_off);
    endproperty
    a_off_pos: assert property (p_off_pos)
        else $error("off lamp disagrees with position");
    property p_local_on; led_local |-> !led_off; endproperty
    a_local_on: assert property (p_local_on)
        else $error("local and off lamps both lit");
    // Depth 3 is one sample past the smoothing window, which ends at depth 4.
    property p_local_src; $rose(led_local) |-> $past(dil_mode_select, 3) != 0;
    endproperty
    a_local_src: assert property (p_local_src)
        else $error("local lamp without a local switch");
    property p_off_src; $rose(led_off) |-> $past(sel_all, 3) == 8'h00;
    endproperty
    a_off_src: assert property (p_off_src)
        else $error("off lamp while a mode was requested");
    // A route only permutes the inputs, so the count of ones survives.
    property p_perm; 1 |=> ring_tx == 4'h0 ||
        $countones(ring_tx) == $countones($past(ring_rx)); endproperty
    a_perm: assert property (p_perm)
        else $error("transmit lines are no permutation");
    // ======================================================================
    // Register bus.
    property p_bhold; s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read answer dropped");
    property p_wresp; s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |-> ##[1:2] s_axi_bvalid; endproperty
    a_wresp: assert property (p_wresp) else $error("write answer late");
    property p_rresp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rresp: assert property (p_rresp) else $error("read answer late");
endmodule
bind rps_switch rps_monitor u_mon (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_bresp(s_axi_bresp), .s_axi_rdata(s_axi_rdata),
    .dil_mode_select(dil_mode_select), .ring_rx(ring_rx), .ring_tx(ring_tx),
    .port_one_mode_select(port_one_mode_select),
    .port_two_mode_select(port_two_mode_select),
    .port_three_mode_select(port_three_mode_select),
    .port_four_mode_select(port_four_mode_select),
    .led_position(led_position), .led_local(led_local), .led_off(led_off));

// ==== test/rps_ring_nodes.sv ====
// Model of the ring nodes that feed the four receive lines.
`timescale 1ns/1ns
module rps_ring_nodes (
    // Clock and receive lines
    input  wire       aclk,
    output reg  [3:0] ring_rx = 4'h1
);
    // A new pattern every cycle exposes a stale or wrong route; a step of
    // five visits all sixteen values.
    always @(posedge aclk)
    begin
        ring_rx <= ring_rx + 4'h5;
    end
endmodule

// ==== test/ring_port_switch_control_test.sv ====
// Self-checking bench of the ring switch.
`timescale 1ns/1ns
`include "rps_map.vh"
module ring_port_switch_control_test;
    reg         aclk = 1'b0, aresetn = 1'b0;
    reg  [3:0]  awaddr = 4'h0, araddr = 4'h0, dil = 4'h0, rem = 4'h0;
    reg  [31:0] wdata = 32'h0;
    reg         awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    wire        awready, wready, bvalid, arready, rvalid, llocal, loff;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    wire [3:0]  rx, tx;
    wire [2:0]  lpos;
    reg  [3:0]  rx_prev;
    integer     num_errors = 0, num_checks = 0;
    // Clock, and the receive pattern that the next edge will route.
    always #25 aclk = ~aclk;
    always @(negedge aclk) rx_prev = rx;
    rps_ring_nodes nodes (.aclk(aclk), .ring_rx(rx));
    rps_switch #(.SMOOTH_CYC(4)) dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .dil_mode_select(dil),
        .port_one_mode_select(rem[0]), .port_two_mode_select(rem[1]),
        .port_three_mode_select(rem[2]), .port_four_mode_select(rem[3]),
        .ring_rx(rx), .ring_tx(tx), .led_position(lpos),
        .led_local(llocal), .led_off(loff));
    task chk(input [31:0] got, exp, input [8*10:1] what);
        begin
            num_checks = num_checks + 1;
            if (got !== exp)
            begin
                num_errors = num_errors + 1;
                $display("BAD %0t %0s got %h want %h", $time, what, got, exp);
            end
        end
    endtask
    // Write: each channel released at its own handshake; bready raised
    // only once the answer shows, so the held answer is exercised too.
    task wr(input [3:0] a, input [31:0] d, input [1:0] er);
        begin
            awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
            do begin
                @(posedge aclk);
                if (awvalid && awready) awvalid <= 1'b0;
                if (wvalid && wready) wvalid <= 1'b0;
                if (bvalid) bready <= 1'b1;
            end while (!(bvalid && bready));
            bready <= 1'b0;
            chk(bresp, er, "bresp");
        end
    endtask
    task rd(input [3:0] a, input [31:0] ed, input [1:0] er);
        begin
            araddr <= a; arvalid <= 1'b1;
            do begin
                @(posedge aclk);
                if (arvalid && arready) arvalid <= 1'b0;
                if (rvalid) rready <= 1'b1;
            end while (!(rvalid && rready));
            rready <= 1'b0;
            chk(rdata, ed, "rdata");
            chk(rresp, er, "rresp");
        end
    endtask
    // Receive line that feeds transmit line d in mode m.
    function [1:0] src(input [2:0] m, input [1:0] d);
        case (m)
            3'h1: src = d ^ 2'h1;
            3'h2: src = d ^ 2'h2;
            3'h3: src = 2'h3 - d;
            3'h4: src = d + 2'h1;
            default: src = d;
        endcase
    endfunction
    // Apply a selection, let smoothing finish, judge lamps and routes.
    task sel(input [3:0] d, r, input [2:0] m, input lc);
        integer k;
        begin
            dil <= d;
            rem <= r;
            repeat (12) @(posedge aclk);
            #1;
            chk(lpos, m, "position");
            chk(llocal, lc, "local");
            chk(loff, m == 3'h0, "off");
            for (k = 0; k < 4; k = k + 1)
                chk(tx[k], rx_prev[src(m, k[1:0])], "route");
            @(posedge aclk);
        end
    endtask
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", num_checks, num_errors);
            if (num_errors == 0 && num_checks > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    // Watchdog, far beyond the roughly 150 cycles the tests need.
    initial
    begin
        repeat (3000) @(posedge aclk);
        num_errors = num_errors + 1;
        end_of_test;
    end
    // Main sequence.
    integer m;
    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        #1;
        chk(loff, 1, "reset off");
        @(posedge aclk);
        rd(`RPS_CTRL_ADDR, `RPS_CTRL_RESET, `RPS_RESP_OKAY);
        $display("test reset done");
        for (m = 1; m <= 4; m = m + 1)
            sel(4'h0, 4'h1 << (m - 1), m[2:0], 1'b0);
        sel(4'h4, 4'h1, 3'h3, 1'b1);
        sel(4'h0, 4'ha, 3'h2, 1'b0);
        rd(`RPS_STATUS_ADDR, 32'h0000_a002, `RPS_RESP_OKAY);
        $display("test modes done");
        wr(`RPS_CTRL_ADDR, 32'h0000_0000, `RPS_RESP_OKAY);
        repeat (2) @(posedge aclk);
        #1;
        chk(tx, 4'h0, "fwd off");
        @(posedge aclk);
        wr(`RPS_CTRL_ADDR, 32'h0000_0001, `RPS_RESP_OKAY);
        wr(`RPS_STATUS_ADDR, 32'h0000_0000, `RPS_RESP_OKAY);
        wr(4'h8, 32'h0000_0001, `RPS_RESP_SLVERR);
        rd(4'h8, 32'h0000_0000, `RPS_RESP_SLVERR);
        $display("test registers done");
        sel(4'h0, 4'h0, 3'h0, 1'b0);
        rem <= 4'h2;
        repeat (2) @(posedge aclk);
        sel(4'h0, 4'h0, 3'h0, 1'b0);
        $display("test glitch done");
        end_of_test;
    end
endmodule
